// File: shared/oscsc_defs.svh
// Register map, field positions, reset values and decode constants of the oscillator sync control
// How it works
// RQ1: With force-release clear, the distribution stays held in sync until the output loop first locks, then is released once with all dividers aligned.
// RQ2: With force-release set, the lock state is ignored and the distribution is released at once.
// RQ3: With the reference-valid override clear, the output loop reference is valid only when the input loop indicator says so.
// RQ4: With the reference-valid override set, the output loop reference is treated as valid regardless of the input loop.
// RQ5: The midpoint-force bit drives the oscillator control voltage to midscale when set and leaves normal operation when clear.
// RQ6: Writing one to the calibrate bit starts calibration, and the bit keeps reading one until software writes zero.
// RQ7: Writing zero to the calibrate bit resets calibration, so a fresh calibration needs a zero and then a one.
// RQ8: The 3-bit divider code 000 to 111 selects division by 4 to 11, and the divided clock feeds every output channel.
// RQ9: The second-pole resistor code in bits 7:6 selects 900, 450, 300 or 225 ohms.
// RQ10: The zero resistor code in bits 5:3 selects 3250, 2750, 2250, 2100 and 3000 ohms for codes 000 to 100.
// RQ11: The divider power-down bit stops the oscillator divider when set and lets it run when clear.
// RQ12: Software keeps the reserved bits of the control and divider registers at zero.
`ifndef OSCSC_DEFS_SVH
`define OSCSC_DEFS_SVH

`define OSCSC_ADDR_W          10
`define OSCSC_CTRL_ADDR       10'h0f3
`define OSCSC_DIVC_ADDR       10'h0f4
`define OSCSC_LF_ADDR         10'h0f5

`define OSCSC_CTRL_FORCE_BIT  4
`define OSCSC_CTRL_REFOV_BIT  3
`define OSCSC_CTRL_MID_BIT    2
`define OSCSC_CTRL_CAL_BIT    1
`define OSCSC_DIVC_PD_BIT     3
`define OSCSC_DIVC_CODE_LSB   0
`define OSCSC_LF_POLE_LSB     6
`define OSCSC_LF_ZERO_LSB     3
`define OSCSC_LF_CPOLE_LSB    0

`define OSCSC_CTRL_RST        8'h00
`define OSCSC_DIVC_RST        8'h00
`define OSCSC_LF_RST          8'h00

`define OSCSC_DIV_BASE        4'h4
`define OSCSC_POLE_OHM_0      10'h384
`define OSCSC_POLE_OHM_1      10'h1c2
`define OSCSC_POLE_OHM_2      10'h12c
`define OSCSC_POLE_OHM_3      10'h0e1
`define OSCSC_ZERO_OHM_0      12'hcb2
`define OSCSC_ZERO_OHM_1      12'habe
`define OSCSC_ZERO_OHM_2      12'h8ca
`define OSCSC_ZERO_OHM_3      12'h834
`define OSCSC_ZERO_OHM_4      12'hbb8
`define OSCSC_ZERO_OHM_5      12'h9c4
`define OSCSC_ZERO_OHM_6      12'h7d0
`define OSCSC_ZERO_OHM_7      12'h73a

`endif

// File: shared/oscsc_pkg.sv
// Types and decode functions of the oscillator sync control
`include "oscsc_defs.svh"
package oscsc_pkg;

    typedef enum logic [1:0] {
        OSCSC_HOLD = 2'b01,
        OSCSC_FREE = 2'b10
    } oscsc_sync_t;

    typedef struct packed {
        logic force_release;
        logic ref_override;
        logic midpoint;
        logic calibrate;
    } oscsc_ctrl_t;

    typedef struct packed {
        logic       power_down;
        logic [2:0] code;
    } oscsc_divc_t;

    typedef struct packed {
        logic [1:0] pole;
        logic [2:0] zero;
        logic [2:0] cpole;
    } oscsc_lf_t;

    function automatic logic [3:0] oscsc_div_ratio(input logic [2:0] code);
        return `OSCSC_DIV_BASE + {1'b0, code};
    endfunction

    function automatic logic [9:0] oscsc_pole_ohms(input logic [1:0] code);
        case (code)
            2'h0:    return `OSCSC_POLE_OHM_0;
            2'h1:    return `OSCSC_POLE_OHM_1;
            2'h2:    return `OSCSC_POLE_OHM_2;
            default: return `OSCSC_POLE_OHM_3;
        endcase
    endfunction

    function automatic logic [11:0] oscsc_zero_ohms(input logic [2:0] code);
        case (code)
            3'h0:    return `OSCSC_ZERO_OHM_0;
            3'h1:    return `OSCSC_ZERO_OHM_1;
            3'h2:    return `OSCSC_ZERO_OHM_2;
            3'h3:    return `OSCSC_ZERO_OHM_3;
            3'h4:    return `OSCSC_ZERO_OHM_4;
            3'h5:    return `OSCSC_ZERO_OHM_5;
            3'h6:    return `OSCSC_ZERO_OHM_6;
            default: return `OSCSC_ZERO_OHM_7;
        endcase
    endfunction

endpackage

// File: verif/tb_top.sv
// Self-checking testbench of the oscillator sync control
`timescale 1ns/100ps
`include "oscsc_defs.svh"
module tb_top import oscsc_pkg::*;;
    logic        sys_clk_in;
    logic        rst_in;
    logic        reg_wr_in;
    logic        reg_rd_in;
    logic [9:0]  reg_addr_in;
    logic [7:0]  reg_wdata_in;
    logic        output_loop_lock_in;
    logic        input_loop_ref_valid_in;
    logic [7:0]  reg_rdata_out;
    logic        dist_sync_hold_out;
    logic        ref_valid_out;
    logic        vco_midscale_out;
    logic        cal_run_out;
    logic        cal_start_out;
    logic        cal_reset_out;
    logic [3:0]  div_ratio_out;
    logic        div_clk_out;
    logic [9:0]  second_pole_ohms_out;
    logic [11:0] zero_ohms_out;
    int          mismatches;
    int          cmp_count;

    oscsc_top uut (
        .sys_clk_in              (sys_clk_in),
        .rst_in                  (rst_in),
        .reg_wr_in               (reg_wr_in),
        .reg_rd_in               (reg_rd_in),
        .reg_addr_in             (reg_addr_in),
        .reg_wdata_in            (reg_wdata_in),
        .output_loop_lock_in     (output_loop_lock_in),
        .input_loop_ref_valid_in (input_loop_ref_valid_in),
        .reg_rdata_out           (reg_rdata_out),
        .dist_sync_hold_out      (dist_sync_hold_out),
        .ref_valid_out           (ref_valid_out),
        .vco_midscale_out        (vco_midscale_out),
        .cal_run_out             (cal_run_out),
        .cal_start_out           (cal_start_out),
        .cal_reset_out           (cal_reset_out),
        .div_ratio_out           (div_ratio_out),
        .div_clk_out             (div_clk_out),
        .second_pole_ohms_out    (second_pole_ohms_out),
        .zero_ohms_out           (zero_ohms_out)
    );

    initial begin
        sys_clk_in = 1'b0;
        forever #4 sys_clk_in = ~sys_clk_in;
    end

    task automatic finish_test;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // Every task starts and ends 1 ns after a rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        reg_wr_in = 1'b1;
        reg_addr_in = a;
        reg_wdata_in = d;
        cyc(1);
        reg_wr_in = 1'b0;
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
        reg_rd_in = 1'b1;
        reg_addr_in = a;
        cyc(1);
        reg_rd_in = 1'b0;
        cyc(1);
        chk({4'h0, reg_rdata_out}, {4'h0, exp}, "read data");
    endtask

    // Counts high samples of the divided clock over n cycles
    task automatic count_hi(input int n, output int hi);
        hi = 0;
        for (int k = 0; k < n; k++) begin
            if (div_clk_out === 1'b1) begin
                hi++;
            end
            cyc(1);
        end
    endtask

    task automatic do_reset;
        rst_in = 1'b1;
        cyc(10);
        rst_in = 1'b0;
        cyc(3);
    endtask

    task automatic t_reset;
        chk(12'(dist_sync_hold_out), 12'h001, "hold at reset");
        chk(12'(ref_valid_out), 12'h000, "ref at reset");
        chk(12'(vco_midscale_out), 12'h000, "mid at reset");
        chk(12'({cal_run_out, cal_start_out, cal_reset_out}), 12'h001, "cal at reset");
        chk(12'(div_ratio_out), 12'h004, "ratio at reset");
        chk(12'(div_clk_out), 12'h000, "divclk at reset");
        chk(12'(second_pole_ohms_out), 12'd900, "pole at reset");
        chk(zero_ohms_out, 12'd3250, "zero at reset");
        rd_chk(`OSCSC_CTRL_ADDR, 8'h00);
        rd_chk(`OSCSC_DIVC_ADDR, 8'h00);
        rd_chk(`OSCSC_LF_ADDR, 8'h00);
        wr(10'h0f6, 8'hff);
        rd_chk(10'h0f6, 8'h00);
    endtask

    task automatic t_ref;
        input_loop_ref_valid_in = 1'b1;
        cyc(3);
        chk(12'(ref_valid_out), 12'h001, "ref follows valid");
        input_loop_ref_valid_in = 1'b0;
        cyc(3);
        chk(12'(ref_valid_out), 12'h000, "ref follows invalid");
        wr(`OSCSC_CTRL_ADDR, 8'h08);
        cyc(2);
        chk(12'(ref_valid_out), 12'h001, "ref override");
        wr(`OSCSC_CTRL_ADDR, 8'h00);
        cyc(2);
        chk(12'(ref_valid_out), 12'h000, "override cleared");
    endtask

    task automatic t_mid;
        wr(`OSCSC_CTRL_ADDR, 8'h04);
        cyc(2);
        chk(12'(vco_midscale_out), 12'h001, "midscale on");
        wr(`OSCSC_CTRL_ADDR, 8'h00);
        cyc(2);
        chk(12'(vco_midscale_out), 12'h000, "midscale off");
    endtask

    task automatic t_cal;
        wr(`OSCSC_CTRL_ADDR, 8'h02);
        cyc(1);
        chk(12'({cal_run_out, cal_start_out, cal_reset_out}), 12'h006, "cal start");
        cyc(1);
        chk(12'(cal_start_out), 12'h000, "start is one pulse");
        cyc(6);
        chk(12'(cal_run_out), 12'h001, "cal bit sticks");
        rd_chk(`OSCSC_CTRL_ADDR, 8'h02);
        wr(`OSCSC_CTRL_ADDR, 8'h02);
        cyc(1);
        chk(12'(cal_start_out), 12'h000, "no restart without zero");
        wr(`OSCSC_CTRL_ADDR, 8'h00);
        cyc(2);
        chk(12'({cal_run_out, cal_reset_out}), 12'h001, "cal reset");
        wr(`OSCSC_CTRL_ADDR, 8'h02);
        cyc(1);
        chk(12'(cal_start_out), 12'h001, "fresh start");
    endtask

    task automatic t_lock;
        int hi;
        count_hi(20, hi);
        chk(12'(hi), 12'h000, "divider static while held");
        chk(12'(dist_sync_hold_out), 12'h001, "held until lock");
        output_loop_lock_in = 1'b1;
        cyc(2);
        chk(12'(dist_sync_hold_out), 12'h001, "hold before sync delay");
        cyc(1);
        chk(12'(dist_sync_hold_out), 12'h000, "release on lock");
        output_loop_lock_in = 1'b0;
        count_hi(8, hi);
        chk(12'(hi), 12'h004, "divider runs by 4");
        chk(12'(dist_sync_hold_out), 12'h000, "lock loss ignored");
    endtask

    task automatic t_div;
        int r;
        int hi;
        for (int c = 0; c < 8; c++) begin
            r = 4 + c;
            wr(`OSCSC_DIVC_ADDR, 8'(c));
            cyc(2);
            chk(12'(div_ratio_out), 12'(r), "ratio");
            cyc(24);
            count_hi(2 * r, hi);
            chk(12'(hi), 12'(2 * (r / 2)), "divided clock");
        end
        wr(`OSCSC_DIVC_ADDR, 8'h0f);
        cyc(2);
        count_hi(12, hi);
        chk(12'(hi), 12'h000, "divider powered down");
        wr(`OSCSC_DIVC_ADDR, 8'h07);
        cyc(26);
        count_hi(22, hi);
        chk(12'(hi), 12'd10, "divider resumes");
    endtask

    task automatic t_lf;
        int         pole_ohm [4] = '{900, 450, 300, 225};
        int         zero_ohm [8] = '{3250, 2750, 2250, 2100, 3000, 2500, 2000, 1850};
        logic [7:0] d;
        for (int p = 0; p < 4; p++) begin
            for (int z = 0; z < 8; z++) begin
                d = {2'(p), 3'(z), 3'(7 - z)};
                wr(`OSCSC_LF_ADDR, d);
                cyc(2);
                chk(12'(second_pole_ohms_out), 12'(pole_ohm[p]), "pole ohms");
                chk(zero_ohms_out, 12'(zero_ohm[z]), "zero ohms");
                rd_chk(`OSCSC_LF_ADDR, d);
            end
        end
    endtask

    task automatic t_force;
        do_reset();
        chk(12'(dist_sync_hold_out), 12'h001, "held after reset");
        wr(`OSCSC_CTRL_ADDR, 8'h10);
        cyc(2);
        chk(12'(dist_sync_hold_out), 12'h000, "forced release");
        wr(`OSCSC_CTRL_ADDR, 8'h1e);
        rd_chk(`OSCSC_CTRL_ADDR, 8'h1e);
        wr(`OSCSC_DIVC_ADDR, 8'h0f);
        rd_chk(`OSCSC_DIVC_ADDR, 8'h0f);
    endtask

    initial begin
        mismatches = 0;
        cmp_count = 0;
        rst_in = 1'b1;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        reg_addr_in = 10'h000;
        reg_wdata_in = 8'h00;
        output_loop_lock_in = 1'b0;
        input_loop_ref_valid_in = 1'b0;
        #1;
        do_reset();
        t_reset();
        t_ref();
        t_mid();
        t_cal();
        t_lock();
        t_div();
        t_lf();
        t_force();
        finish_test();
    end

    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        mismatches++;
        $display("BAD %0t timeout", $time);
        finish_test();
    end
endmodule // tb_top

// File: verilog/oscsc_divider.sv
// Oscillator divider: divides by a ratio of 4 to 11, held static while stopped
`timescale 1ns/100ps
module oscsc_divider import oscsc_pkg::*; #(
    parameter int CNT_W = 4
) (
    input  wire logic             sys_clk_in,
    input  wire logic             rst_in,
    input  wire logic [CNT_W-1:0] ratio_in,
    input  wire logic             stop_in,
    output logic                  div_clk_out
);

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             next_div_clk;

    always_comb begin
        if (stop_in) begin                                         // RQ11
            // Park on the last count so the first edge after a stop opens a full period
            next_cnt = ratio_in - 1'b1;
        end else if (cnt >= ratio_in - 1'b1) begin                 // RQ8
            next_cnt = '0;
        end else begin
            next_cnt = cnt + 1'b1;
        end
        next_div_clk = !stop_in && (next_cnt < (ratio_in >> 1));
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cnt         <= '0;
            div_clk_out <= 1'b0;
        end else begin
            cnt         <= next_cnt;
            div_clk_out <= next_div_clk;
        end
    end

    // Cycles since the last rising edge, for the period check
    logic [CNT_W:0] gap;
    logic           seen_rise;
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || stop_in) begin
            gap       <= '0;
            seen_rise <= 1'b0;
        end else if (next_div_clk && !div_clk_out) begin
            gap       <= '0;
            seen_rise <= 1'b1;
        end else begin
            gap       <= gap + 1'b1;
        end
    end

    property p_div_stopped;
        @(posedge sys_clk_in) disable iff (rst_in)
        stop_in |=> !div_clk_out;
    endproperty
    a_div_stopped: assert property (p_div_stopped) else $error("divider ran while stopped"); // RQ11

    property p_div_period;
        @(posedge sys_clk_in) disable iff (rst_in)
        (seen_rise && !stop_in && $stable(ratio_in) && next_div_clk && !div_clk_out)
            |-> (gap == {1'b0, ratio_in} - 1'b1);
    endproperty
    a_div_period: assert property (p_div_period) else $error("divider period wrong"); // RQ8

endmodule // oscsc_divider

// File: verilog/oscsc_top.sv
// Oscillator sync control: control registers, sync release, reference qualify, calibration
`timescale 1ns/100ps
module oscsc_top import oscsc_pkg::*; (
    input  wire logic                     sys_clk_in,
    input  wire logic                     rst_in,
    input  wire logic                     reg_wr_in,
    input  wire logic                     reg_rd_in,
    input  wire logic [`OSCSC_ADDR_W-1:0] reg_addr_in,
    input  wire logic [7:0]               reg_wdata_in,
    input  wire logic                     output_loop_lock_in,
    input  wire logic                     input_loop_ref_valid_in,
    output logic [7:0]                    reg_rdata_out,
    output logic                          dist_sync_hold_out,
    output logic                          ref_valid_out,
    output logic                          vco_midscale_out,
    output logic                          cal_run_out,
    output logic                          cal_start_out,
    output logic                          cal_reset_out,
    output logic [3:0]                    div_ratio_out,
    output logic                          div_clk_out,
    output logic [9:0]                    second_pole_ohms_out,
    output logic [11:0]                   zero_ohms_out
);

    // Register file
    oscsc_ctrl_t ctrl;
    oscsc_ctrl_t next_ctrl;
    oscsc_divc_t divc;
    oscsc_divc_t next_divc;
    oscsc_lf_t   lf;
    oscsc_lf_t   next_lf;
    logic [7:0]  next_rdata;
    logic        ctrl_wr;
    logic [2:0]  div_code;

    assign ctrl_wr  = reg_wr_in && (reg_addr_in == `OSCSC_CTRL_ADDR);
    assign div_code = divc.code;

    always_comb begin
        next_ctrl  = ctrl;
        next_divc  = divc;
        next_lf    = lf;
        next_rdata = reg_rdata_out;
        if (ctrl_wr) begin
            next_ctrl.force_release = reg_wdata_in[`OSCSC_CTRL_FORCE_BIT];
            next_ctrl.ref_override  = reg_wdata_in[`OSCSC_CTRL_REFOV_BIT];
            next_ctrl.midpoint      = reg_wdata_in[`OSCSC_CTRL_MID_BIT];
            next_ctrl.calibrate     = reg_wdata_in[`OSCSC_CTRL_CAL_BIT];     // RQ6
        end
        if (reg_wr_in && reg_addr_in == `OSCSC_DIVC_ADDR) begin
            next_divc.power_down = reg_wdata_in[`OSCSC_DIVC_PD_BIT];
            next_divc.code       = reg_wdata_in[`OSCSC_DIVC_CODE_LSB +: 3];
        end
        if (reg_wr_in && reg_addr_in == `OSCSC_LF_ADDR) begin
            next_lf.pole  = reg_wdata_in[`OSCSC_LF_POLE_LSB +: 2];
            next_lf.zero  = reg_wdata_in[`OSCSC_LF_ZERO_LSB +: 3];
            next_lf.cpole = reg_wdata_in[`OSCSC_LF_CPOLE_LSB +: 3];
        end
        if (reg_rd_in) begin
            next_rdata = 8'h00;
            case (reg_addr_in)
                `OSCSC_CTRL_ADDR: begin
                    next_rdata[`OSCSC_CTRL_FORCE_BIT] = ctrl.force_release;
                    next_rdata[`OSCSC_CTRL_REFOV_BIT] = ctrl.ref_override;
                    next_rdata[`OSCSC_CTRL_MID_BIT]   = ctrl.midpoint;
                    next_rdata[`OSCSC_CTRL_CAL_BIT]   = ctrl.calibrate;      // RQ6
                end
                `OSCSC_DIVC_ADDR: begin
                    next_rdata[`OSCSC_DIVC_PD_BIT]          = divc.power_down;
                    next_rdata[`OSCSC_DIVC_CODE_LSB +: 3]   = divc.code;
                end
                `OSCSC_LF_ADDR: begin
                    next_rdata = {lf.pole, lf.zero, lf.cpole};
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ctrl          <= oscsc_ctrl_t'(`OSCSC_CTRL_RST);
            divc          <= oscsc_divc_t'(`OSCSC_DIVC_RST);
            lf            <= oscsc_lf_t'(`OSCSC_LF_RST);
            reg_rdata_out <= 8'h00;
        end else begin
            ctrl          <= next_ctrl;
            divc          <= next_divc;
            lf            <= next_lf;
            reg_rdata_out <= next_rdata;
        end
    end

    // Pin synchronisers
    logic lock_s1;
    logic lock_s2;
    logic refv_s1;
    logic refv_s2;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
            refv_s1 <= 1'b0;
            refv_s2 <= 1'b0;
        end else begin
            lock_s1 <= output_loop_lock_in;
            lock_s2 <= lock_s1;
            refv_s1 <= input_loop_ref_valid_in;
            refv_s2 <= refv_s1;
        end
    end

    // Distribution sync release: one-time, stays released until reset
    oscsc_sync_t sync_state;
    oscsc_sync_t next_sync_state;

    always_comb begin
        case (sync_state)
            OSCSC_HOLD: begin
                if (ctrl.force_release || lock_s2) begin             // RQ1 RQ2
                    next_sync_state = OSCSC_FREE;
                end else begin
                    next_sync_state = OSCSC_HOLD;
                end
            end
            OSCSC_FREE: begin
                next_sync_state = OSCSC_FREE;
            end
            default: begin
                next_sync_state = OSCSC_HOLD;
            end
        endcase
    end

    // Status and analog control outputs
    logic        next_ref_valid;
    logic        next_cal_start;
    logic [3:0]  next_div_ratio;

    always_comb begin
        next_ref_valid = ctrl.ref_override || refv_s2;                  // RQ3 RQ4
        next_cal_start = ctrl.calibrate && !cal_run_out;                // RQ6 RQ7
        next_div_ratio = oscsc_div_ratio(divc.code);                    // RQ8
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sync_state           <= OSCSC_HOLD;
            dist_sync_hold_out   <= 1'b1;
            ref_valid_out        <= 1'b0;
            vco_midscale_out     <= 1'b0;
            cal_run_out          <= 1'b0;
            cal_start_out        <= 1'b0;
            cal_reset_out        <= 1'b1;
            div_ratio_out        <= `OSCSC_DIV_BASE;
            second_pole_ohms_out <= `OSCSC_POLE_OHM_0;
            zero_ohms_out        <= `OSCSC_ZERO_OHM_0;
        end else begin
            sync_state           <= next_sync_state;
            dist_sync_hold_out   <= (next_sync_state == OSCSC_HOLD);    // RQ1
            ref_valid_out        <= next_ref_valid;
            vco_midscale_out     <= ctrl.midpoint;                      // RQ5
            cal_run_out          <= ctrl.calibrate;                     // RQ6
            cal_start_out        <= next_cal_start;
            cal_reset_out        <= !ctrl.calibrate;                    // RQ7
            div_ratio_out        <= next_div_ratio;
            second_pole_ohms_out <= oscsc_pole_ohms(lf.pole);           // RQ9
            zero_ohms_out        <= oscsc_zero_ohms(lf.zero);           // RQ10
        end
    end

    // Divider runs only while released and powered; held static keeps channels aligned
    oscsc_divider #(
        .CNT_W (4)
    ) u_divider (
        .sys_clk_in  (sys_clk_in),
        .rst_in      (rst_in),
        .ratio_in    (next_div_ratio),
        .stop_in     (divc.power_down || dist_sync_hold_out),           // RQ11 RQ1
        .div_clk_out (div_clk_out)
    );

    sequence s_waiting;
        (sync_state == OSCSC_HOLD) && !ctrl.force_release && !lock_s2;
    endsequence

    property p_hold_until_lock;
        @(posedge sys_clk_in) disable iff (rst_in)
        s_waiting |=> dist_sync_hold_out;
    endproperty
    a_hold_until_lock: assert property (p_hold_until_lock) else $error("released early"); // RQ1

    property p_release_sticks;
        @(posedge sys_clk_in) disable iff (rst_in)
        lock_s2 |=> !dist_sync_hold_out [*4];
    endproperty
    a_release_sticks: assert property (p_release_sticks) else $error("release not kept"); // RQ1

    property p_force_release;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ctrl.force_release && !lock_s2) |=> !dist_sync_hold_out;
    endproperty
    a_force_release: assert property (p_force_release) else $error("force ignored"); // RQ2

    property p_ref_from_input;
        @(posedge sys_clk_in) disable iff (rst_in)
        !ctrl.ref_override |=> (ref_valid_out == $past(refv_s2));
    endproperty
    a_ref_from_input: assert property (p_ref_from_input) else $error("ref valid wrong"); // RQ3

    property p_ref_override;
        @(posedge sys_clk_in) disable iff (rst_in)
        ctrl.ref_override |=> ref_valid_out;
    endproperty
    a_ref_override: assert property (p_ref_override) else $error("override ignored"); // RQ4

    property p_midscale;
        @(posedge sys_clk_in) disable iff (rst_in)
        1'b1 |=> (vco_midscale_out == $past(ctrl.midpoint));
    endproperty
    a_midscale: assert property (p_midscale) else $error("midscale wrong"); // RQ5

    sequence s_cal_write_one;
        ctrl_wr && reg_wdata_in[`OSCSC_CTRL_CAL_BIT] && !ctrl.calibrate;
    endsequence

    property p_cal_start;
        @(posedge sys_clk_in) disable iff (rst_in)
        s_cal_write_one |=> ##1 (cal_start_out && cal_run_out) ##1 !cal_start_out;
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("calibration start wrong"); // RQ6

    property p_cal_sticky;
        @(posedge sys_clk_in) disable iff (rst_in)
        (cal_run_out && ctrl.calibrate && !ctrl_wr) |=> ##1 cal_run_out;
    endproperty
    a_cal_sticky: assert property (p_cal_sticky) else $error("calibrate cleared itself"); // RQ6

    property p_cal_reset;
        @(posedge sys_clk_in) disable iff (rst_in)
        !ctrl.calibrate |=> (cal_reset_out && !cal_start_out);
    endproperty
    a_cal_reset: assert property (p_cal_reset) else $error("calibration not reset"); // RQ7

    property p_div_decode;
        @(posedge sys_clk_in) disable iff (rst_in)
        1'b1 |=> (div_ratio_out == {1'b0, $past(div_code)} + 4'h4);
    endproperty
    a_div_decode: assert property (p_div_decode) else $error("divider ratio wrong"); // RQ8

    property p_pole_min;
        @(posedge sys_clk_in) disable iff (rst_in)
        (lf.pole == 2'h3) |=> (second_pole_ohms_out == 10'h0e1);
    endproperty
    a_pole_min: assert property (p_pole_min) else $error("pole resistor wrong"); // RQ9

    property p_zero_four;
        @(posedge sys_clk_in) disable iff (rst_in)
        (lf.zero == 3'h4) |=> (zero_ohms_out == 12'hbb8);
    endproperty
    a_zero_four: assert property (p_zero_four) else $error("zero resistor wrong"); // RQ10

endmodule // oscsc_top
